// *** hdl/arnf_filter.sv ***
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module arnf_filter
    import arnf_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_ce,
    // register port
    input  wire logic [ARNF_ADDR_W-1:0] i_addr,
    input  wire logic [31:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [31:0]            o_rdata,
    // received request
    input  wire logic                   i_req_valid,
    input  wire logic [1:0]             i_req_ctx,
    input  wire logic [ARNF_BUS_W-1:0]  i_req_src_bus,
    input  wire logic [ARNF_NODE_W-1:0] i_req_src_node,
    // decision
    output logic                        o_dec_valid,
    output logic                        o_dec_accept,
    // filter view
    output logic      [31:0]            o_lower_filter,
    output logic      [31:0]            o_upper_filter
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ARNF_ADDR_W-1:0] a,
                                 input logic [ARNF_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire lo_set = i_wr && hit(i_addr, ARNF_LOWER_SET_OFS);
    wire lo_clr = i_wr && hit(i_addr, ARNF_LOWER_CLR_OFS);
    wire hi_set = i_wr && hit(i_addr, ARNF_UPPER_SET_OFS);
    wire hi_clr = i_wr && hit(i_addr, ARNF_UPPER_CLR_OFS);
    wire bus_wr = i_wr && hit(i_addr, ARNF_LOCAL_BUS_OFS);

    // ----------------------------------------------------------------
    // filter words: one shared module so both behave identically
    // ----------------------------------------------------------------
    logic [31:0] lower_val;
    logic [31:0] upper_val;

    arnf_rsc_word u_lower
    (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_sync_reg),
        .i_ce      (i_ce),
        .i_set     (lo_set),
        .i_clr     (lo_clr),
        .i_data    (i_wdata),
        .o_value   (lower_val)
    );

    arnf_rsc_word u_upper
    (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_sync_reg),
        .i_ce      (i_ce),
        .i_set     (hi_set),
        .i_clr     (hi_clr),
        .i_data    (i_wdata),
        .o_value   (upper_val)
    );

    // ----------------------------------------------------------------
    // local bus id and counters
    // ----------------------------------------------------------------
    logic [ARNF_BUS_W-1:0] bus_id_reg;
    logic [ARNF_CNT_W-1:0] acc_cnt_reg;
    logic [ARNF_CNT_W-1:0] rej_cnt_reg;
    logic [31:0]           rdata_reg;
    logic                  dvalid_reg;
    logic                  daccept_reg;

    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    // 64 node enables: nodes 51 to 62 are held in the upper word but
    // only nodes up to 50 are mapped; 63 is the broadcast id and never enabled
    logic [63:0] node_en;

    genvar g;
    generate
        for (g = 0; g < ARNF_UPPER_NODES; g++)
        begin : g_upper
            assign node_en[ARNF_UPPER_BASE+g] = upper_val[g];
        end
        for (g = ARNF_UPPER_NODES; g < 32; g++)
        begin : g_unmapped
            assign node_en[ARNF_UPPER_BASE+g] = 1'b0;
        end
    endgenerate
    assign node_en[31:0] = lower_val;

    wire filtered  = (i_req_ctx == ARNF_CTX_PHYS)
                  || (i_req_ctx == ARNF_CTX_REQ_RECEIVE);
    wire is_local  = (i_req_src_bus == bus_id_reg);
    wire local_ok  = node_en[i_req_src_node];
    wire remote_ok = upper_val[ARNF_REMOTE_BIT];
    wire accept    = !filtered || (is_local ? local_ok : remote_ok);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire rd_lo  = hit(i_addr, ARNF_LOWER_SET_OFS) || hit(i_addr, ARNF_LOWER_CLR_OFS);
    wire rd_hi  = hit(i_addr, ARNF_UPPER_SET_OFS) || hit(i_addr, ARNF_UPPER_CLR_OFS);
    wire rd_bus = hit(i_addr, ARNF_LOCAL_BUS_OFS);
    wire rd_st  = hit(i_addr, ARNF_STATUS_OFS);
    wire [31:0] rmux = rd_lo  ? lower_val
                     : rd_hi  ? upper_val
                     : rd_bus ? {{(32-ARNF_BUS_W){1'b0}}, bus_id_reg}
                     : rd_st  ? {rej_cnt_reg, acc_cnt_reg}
                     : 32'h0000_0000;

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    // read data is zeroed outside its answer cycle so no stale word leaks out
    wire [ARNF_BUS_W-1:0] bus_id_next  = bus_wr ? i_wdata[ARNF_BUS_W-1:0] : bus_id_reg;
    wire [31:0]           rdata_next   = i_rd ? rmux : 32'h0000_0000;
    wire                  dvalid_next  = i_req_valid;
    wire                  daccept_next = i_req_valid && accept;
    // counters wrap silently; both halves come back in one read
    wire [ARNF_CNT_W-1:0] acc_cnt_next = (i_req_valid && accept)
                                       ? acc_cnt_reg + 1'b1 : acc_cnt_reg;
    wire [ARNF_CNT_W-1:0] rej_cnt_next = (i_req_valid && !accept)
                                       ? rej_cnt_reg + 1'b1 : rej_cnt_reg;

    // ----------------------------------------------------------------
    // local bus id
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            bus_id_reg <= ARNF_BUS_ID_RST;
        else if (i_ce)
            bus_id_reg <= bus_id_next;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            rdata_reg <= 32'h0000_0000;
        else if (i_ce)
            rdata_reg <= rdata_next;
    end

    // ----------------------------------------------------------------
    // decision
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            dvalid_reg  <= 1'b0;
            daccept_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            dvalid_reg  <= dvalid_next;
            daccept_reg <= daccept_next;
        end
    end

    // ----------------------------------------------------------------
    // event counters
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            acc_cnt_reg <= '0;
            rej_cnt_reg <= '0;
        end
        else if (i_ce)
        begin
            acc_cnt_reg <= acc_cnt_next;
            rej_cnt_reg <= rej_cnt_next;
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_dec_valid    = dvalid_reg;
    assign o_dec_accept   = daccept_reg;
    assign o_lower_filter = lower_val;
    assign o_upper_filter = upper_val;
endmodule : arnf_filter
`default_nettype wire

// *** hdl/arnf_rsc_word.sv ***
`timescale 1ns/1ps
`default_nettype none
module arnf_rsc_word
    import arnf_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    // set and clear strobes with data
    input  wire logic              i_set,
    input  wire logic              i_clr,
    input  wire logic [31:0]       i_data,
    // current value
    output logic      [31:0]       o_value
);
    // ----------------------------------------------------------------
    // read/set/clear word
    // ----------------------------------------------------------------
    logic [31:0] word_reg;
    logic [31:0] word_next;

    // ones set, ones clear, zeros keep; a strobe never hits both ports at once
    assign word_next = i_set ? (word_reg | i_data)
                     : i_clr ? (word_reg & ~i_data) : word_reg;
    assign o_value   = word_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            word_reg <= ARNF_FILTER_RST;
        else if (i_ce)
            word_reg <= word_next;
    end
endmodule : arnf_rsc_word
`default_nettype wire

// *** include/arnf_pkg.sv ***
package arnf_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ARNF_UPPER_SET_OFS   = 12'h100;
    localparam logic [11:0] ARNF_UPPER_CLR_OFS   = 12'h104;
    localparam logic [11:0] ARNF_LOWER_SET_OFS   = 12'h108;
    localparam logic [11:0] ARNF_LOWER_CLR_OFS   = 12'h10C;
    localparam logic [11:0] ARNF_LOCAL_BUS_OFS   = 12'h180;
    localparam logic [11:0] ARNF_STATUS_OFS      = 12'h184;
    localparam int          ARNF_ADDR_W          = 12;
    localparam int          ARNF_DATA_W          = 32;
    localparam logic [31:0] ARNF_FILTER_RST      = 32'h0000_0000;
    localparam logic [9:0]  ARNF_BUS_ID_RST      = 10'h3FF;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int          ARNF_REMOTE_BIT      = 31;
    localparam int          ARNF_UPPER_NODES     = 19;
    localparam int          ARNF_UPPER_BASE      = 32;
    localparam int          ARNF_NODE_W          = 6;
    localparam int          ARNF_BUS_W           = 10;
    localparam int          ARNF_CNT_W           = 16;
    // ----------------------------------------------------------------
    // packet destination contexts
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ARNF_CTX_OTHER,
        ARNF_CTX_PHYS,
        ARNF_CTX_REQ_RECEIVE
    } arnf_ctx_t;
endpackage : arnf_pkg

// *** tb/arnf_filter_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module arnf_filter_sva
    import arnf_pkg::*;
(
    // watched ports
    input wire logic        i_sys_clk,
    input wire logic        i_arst_n,
    input wire logic        i_ce,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_req_valid,
    input wire logic [1:0]  i_req_ctx,
    input wire logic [9:0]  i_req_src_bus,
    input wire logic [5:0]  i_req_src_node,
    input wire logic        o_dec_valid,
    input wire logic        o_dec_accept,
    input wire logic [31:0] o_lower_filter,
    input wire logic [31:0] o_upper_filter
);
    // bus id is hidden, so the bench keeps it at its reset value while requests run
    wire logic wr_ok = i_wr && i_ce;
    wire logic filt  = i_req_valid && i_ce && (i_req_ctx == 2'h1 || i_req_ctx == 2'h2);
    wire logic loc   = i_req_src_bus == ARNF_BUS_ID_RST;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_lower_set;
        wr_ok && i_addr == ARNF_LOWER_SET_OFS;
    endsequence
    sequence s_lower_clr;
        wr_ok && i_addr == ARNF_LOWER_CLR_OFS;
    endsequence
    chk_lower_set: assert property (s_lower_set |=>
        o_lower_filter == ($past(o_lower_filter) | $past(i_wdata))) else $error("lower set");
    chk_lower_clr: assert property (s_lower_clr |=>
        o_lower_filter == ($past(o_lower_filter) & ~$past(i_wdata))) else $error("lower clr");
    chk_dec_pulse: assert property (i_req_valid && i_ce |=> o_dec_valid)
        else $error("no decision");
    chk_accept_valid: assert property (o_dec_accept |-> o_dec_valid)
        else $error("stray accept");
    chk_lower_node: assert property (filt && loc && !i_req_src_node[5] |=>
        o_dec_accept == $past(o_lower_filter[i_req_src_node[4:0]])) else $error("lower node");
    chk_upper_node: assert property (filt && loc && i_req_src_node inside {[32:50]} |=>
        o_dec_accept == $past(o_upper_filter[i_req_src_node[4:0]])) else $error("upper node");
    chk_remote_bus: assert property (filt && !loc |=>
        o_dec_accept == $past(o_upper_filter[ARNF_REMOTE_BIT])) else $error("remote bus");
    chk_reset_zero: assert property (disable iff (1'b0) !i_arst_n |->
        o_lower_filter == 32'h0 && o_upper_filter == 32'h0) else $error("not cleared");
endmodule : arnf_filter_sva
bind arnf_filter arnf_filter_sva u_arnf_filter_sva (.*);
`default_nettype wire

// *** tb/arnf_remote_node.sv ***
`timescale 1ns/1ps
`default_nettype none
module arnf_remote_node
(
    // clock
    input  wire logic       i_sys_clk,
    // request
    output logic            o_req_valid,
    output logic      [1:0] o_req_ctx,
    output logic      [9:0] o_req_bus,
    output logic      [5:0] o_req_node
);
    initial
        {o_req_valid, o_req_ctx, o_req_bus, o_req_node} = '0;
    // ids are inverted after the pulse so a stale id never looks current
    task automatic send(input logic [1:0] c, input logic [9:0] b, input logic [5:0] n);
        @(posedge i_sys_clk);
        {o_req_valid, o_req_ctx, o_req_bus, o_req_node} <= {1'b1, c, b, n};
        @(posedge i_sys_clk);
        {o_req_valid, o_req_ctx, o_req_bus, o_req_node} <= {1'b0, ~c, ~b, ~n};
    endtask : send
endmodule : arnf_remote_node
`default_nettype wire

// *** tb/tb_arnf_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_arnf_filter
    import arnf_pkg::*;
;
    logic        i_sys_clk = 1'b0;
    logic        i_arst_n = 1'b1;
    logic        i_ce = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [11:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic [31:0] o_rdata, o_lower_filter, o_upper_filter, lo = '0, up = '0;
    logic        i_req_valid, o_dec_valid, o_dec_accept;
    logic [1:0]  i_req_ctx;
    logic [9:0]  i_req_src_bus;
    logic [5:0]  i_req_src_node;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n_acc = 0;
    int          n_rej = 0;
    logic [5:0]  cn [6] = '{6'h00, 6'h1F, 6'h20, 6'h32, 6'h33, 6'h3F};
    arnf_filter u_arnf_filter (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_req_valid(i_req_valid), .i_req_ctx(i_req_ctx), .i_req_src_bus(i_req_src_bus),
        .i_req_src_node(i_req_src_node), .o_dec_valid(o_dec_valid),
        .o_dec_accept(o_dec_accept), .o_lower_filter(o_lower_filter),
        .o_upper_filter(o_upper_filter));
    arnf_remote_node u_arnf_remote_node (.i_sys_clk(i_sys_clk), .o_req_valid(i_req_valid),
        .o_req_ctx(i_req_ctx), .o_req_bus(i_req_src_bus), .o_req_node(i_req_src_node));
    initial
        forever #2.5 i_sys_clk = ~i_sys_clk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic exp_acc(input logic [1:0] c, input logic [9:0] b, input logic [5:0] n);
        if (c != 2'h1 && c != 2'h2)
            return 1'b1;
        if (b != ARNF_BUS_ID_RST)
            return up[ARNF_REMOTE_BIT];
        if (n < 6'd32)
            return lo[n[4:0]];
        return (n <= 6'd50) ? up[n[4:0]] : 1'b0;
    endfunction : exp_acc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        if (i_ce)
            case (a)
                ARNF_UPPER_SET_OFS: up |= d;
                ARNF_UPPER_CLR_OFS: up &= ~d;
                ARNF_LOWER_SET_OFS: lo |= d;
                ARNF_LOWER_CLR_OFS: lo &= ~d;
                default: ;
            endcase
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask : rd
    task automatic req(input logic [1:0] c, input logic [9:0] b, input logic [5:0] n);
        u_arnf_remote_node.send(c, b, n);
        #1;
        chk(o_dec_valid, 1'b1);
        chk(o_dec_accept, exp_acc(c, b, n));
        if (exp_acc(c, b, n))
            n_acc++;
        else
            n_rej++;
    endtask : req
    initial
    begin
        i_arst_n <= 1'b0;
        void'($urandom(7656));
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        for (int i = 0; i < 4; i++)
            rd(ARNF_UPPER_SET_OFS + 12'(4 * i), 32'h0);
        $display("test reset done");
        wr(ARNF_LOWER_SET_OFS, 32'hFFFF_FFFF);
        wr(ARNF_LOWER_CLR_OFS, 32'h0);
        wr(12'h1F0, 32'hFFFF_FFFF);
        rd(12'h1F0, 32'h0);
        rd(ARNF_LOWER_CLR_OFS, lo);
        for (int i = 0; i < 40; i++)
        begin
            wr(ARNF_UPPER_SET_OFS + 12'(4 * ($urandom % 4)), $urandom);
            rd(ARNF_LOWER_SET_OFS, lo);
            rd(ARNF_UPPER_CLR_OFS, up);
        end
        @(posedge i_sys_clk);
        i_ce <= 1'b0;
        wr(ARNF_LOWER_SET_OFS, ~lo);
        wr(ARNF_LOWER_CLR_OFS, lo);
        #1;
        chk(o_lower_filter, lo);
        chk(o_upper_filter, up);
        i_ce <= 1'b1;
        rd(ARNF_LOCAL_BUS_OFS, 32'(ARNF_BUS_ID_RST));
        wr(ARNF_LOCAL_BUS_OFS, 32'h0000_0155);
        rd(ARNF_LOCAL_BUS_OFS, 32'h0000_0155);
        wr(ARNF_LOCAL_BUS_OFS, 32'(ARNF_BUS_ID_RST));
        $display("test registers done");
        for (int i = 0; i < 160; i++)
        begin
            if (i % 8 == 0)
                wr(ARNF_UPPER_SET_OFS + 12'(4 * ($urandom % 4)), $urandom);
            req(2'($urandom), ($urandom % 4 == 0) ? 10'($urandom) : ARNF_BUS_ID_RST, 6'($urandom));
        end
        foreach (cn[k])
            req(2'h1, ARNF_BUS_ID_RST, cn[k]);
        rd(ARNF_STATUS_OFS, {16'(n_rej), 16'(n_acc)});
        $display("test requests done");
        i_arst_n <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk(o_lower_filter, 32'h0000_0000);
        chk(o_upper_filter, 32'h0000_0000);
        lo = '0;
        up = '0;
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        rd(ARNF_LOWER_CLR_OFS, 32'h0000_0000);
        rd(ARNF_STATUS_OFS, 32'h0000_0000);
        $display("test mid reset done");
        close_out();
    end
endmodule : tb_arnf_filter
`default_nettype wire
